// *** efpv_cfg.svh ***
`ifndef EFPV_CFG_SVH
`define EFPV_CFG_SVH

// ----------------------------------------
// register map of the flash controller
// ----------------------------------------
`define EFPV_ACCESS_CLAIM_OFS 32'h0000_01FC
`define EFPV_WDBUF_BASE_OFS 32'h0000_0080
`define EFPV_CMD_OFS 32'h0000_0148
`define EFPV_STATUS_OFS 32'h0000_0120

// ----------------------------------------
// field positions and values
// ----------------------------------------
`define EFPV_CMD_CODE_MSB 31
`define EFPV_CMD_CODE_LSB 24
`define EFPV_CMD_PAGE_MSB 23
`define EFPV_CMD_PAGE_LSB 0
`define EFPV_ACCESS_CLAIM_VAL 32'h0000_0001
`define EFPV_ACCESS_FREE_VAL 32'h0000_0000
`define EFPV_STATUS_BUSY_BIT 0
`define EFPV_STATUS_ERR_BIT 1

// ----------------------------------------
// command codes
// ----------------------------------------
`define EFPV_OP_PROG_LOAD 8'h01
`define EFPV_OP_PROG_DATA_ADDR 8'h02
`define EFPV_OP_PROG_LAUNCH 8'h03
`define EFPV_OP_VERIFY_LOAD 8'h04
`define EFPV_OP_VERIFY_DATA_ADDR 8'h05
`define EFPV_OP_VERIFY_LAUNCH 8'h06
`define EFPV_OP_PROG_SINGLE 8'h07
`define EFPV_OP_VERIFY_SINGLE 8'h08

// ----------------------------------------
// bus encodings and last step index of each sequence
// ----------------------------------------
`define EFPV_HTRANS_IDLE 2'h0
`define EFPV_HTRANS_NONSEQ 2'h2
`define EFPV_HSIZE_WORD 3'h2
`define EFPV_LAST_STEP_SPLIT 3'h5
`define EFPV_LAST_STEP_SINGLE 3'h1

`endif

// *** efpv_pkg.sv ***
package efpv_pkg;

    typedef enum logic [2:0] {
        EFPV_ST_IDLE = 3'b000,
        EFPV_ST_CLAIM = 3'b001,
        EFPV_ST_FILL = 3'b010,
        EFPV_ST_CMD = 3'b011,
        EFPV_ST_POLL = 3'b100,
        EFPV_ST_FREE = 3'b101
    } efpv_seq_e;

    typedef enum logic [1:0] {
        EFPV_PH_IDLE = 2'b00,
        EFPV_PH_ADDR = 2'b01,
        EFPV_PH_DATA = 2'b10
    } efpv_phase_e;

endpackage

// *** efpv_ahb_xfer.sv ***
`timescale 1ns/1ps
`include "efpv_cfg.svh"

module efpv_ahb_xfer
    import efpv_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // request from the sequencer
    input wire logic req,
    input wire logic [31:0] req_addr,
    input wire logic req_write,
    input wire logic [31:0] req_wdata,
    output logic done,
    output logic [31:0] rdata,
    output logic err,
    // ahb-lite master
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hresp,
    input wire logic [31:0] hrdata
);

    typedef struct packed {
        efpv_phase_e ph;
        logic [31:0] wbuf;
        logic done;
        logic [31:0] rdata;
        logic err;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [31:0] hwdata;
    } efpv_xfer_s;

    efpv_xfer_s s_q;
    efpv_xfer_s s_d;

    // ----------------------------------------
    // single transfers, never pipelined
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        case (s_q.ph)
            EFPV_PH_IDLE: begin
                if (req) begin
                    s_d.ph = EFPV_PH_ADDR;
                    s_d.haddr = req_addr;
                    s_d.hwrite = req_write;
                    s_d.htrans = `EFPV_HTRANS_NONSEQ;
                    s_d.wbuf = req_wdata;
                end
            end
            EFPV_PH_ADDR: begin
                // address taken only when the previous data phase ends
                if (hready) begin
                    s_d.ph = EFPV_PH_DATA;
                    s_d.htrans = `EFPV_HTRANS_IDLE;
                    s_d.hwdata = s_q.wbuf;
                end
            end
            EFPV_PH_DATA: begin
                if (hready) begin
                    s_d.ph = EFPV_PH_IDLE;
                    s_d.done = 1'b1;
                    s_d.rdata = hrdata;
                    s_d.err = hresp;
                end
            end
            default: begin
                s_d.ph = EFPV_PH_IDLE;
                s_d.htrans = `EFPV_HTRANS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign done = s_q.done;
    assign rdata = s_q.rdata;
    assign err = s_q.err;
    assign haddr = s_q.haddr;
    assign htrans = s_q.htrans;
    assign hwrite = s_q.hwrite;
    assign hsize = `EFPV_HSIZE_WORD;
    assign hwdata = s_q.hwdata;

endmodule

// *** efpv_seq.sv ***
// Functional notes
// - Claim register access by writing one first.
// - Fill write data buffer before programming.
// - Data-address program follows completed program load.
// - Program launch follows completed data-address program.
// - Verify load starts after programming finishes.
// - Data-address verify follows completed verify load.
// - Verify launch follows, then await verify completion.
// - Release register access by writing zero.
// - Poll status register after every command.
// - Single-shot verify only after program completion polled.
// - Command word: code high byte, page low.
`timescale 1ns/1ps
`include "efpv_cfg.svh"

module efpv_seq
    import efpv_pkg::*;
#(
    parameter int BUF_WORDS = 32
)(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // user side: buffer loading
    input wire logic load_en,
    input wire logic [5:0] load_idx,
    input wire logic [31:0] load_data,
    // user side: job control
    input wire logic start,
    input wire logic single_shot,
    input wire logic [23:0] page_addr,
    output logic busy,
    output logic done,
    output logic fail,
    // ahb-lite master
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hresp,
    input wire logic [31:0] hrdata
);

    // ----------------------------------------
    // elaboration check
    // ----------------------------------------
    // more than 32 words would run past the buffer window; from 41 words on into the status register
    if (BUF_WORDS < 1 || BUF_WORDS > 32) begin : g_bad_depth
        $error("BUF_WORDS must lie between 1 and 32");
    end

    typedef struct packed {
        efpv_seq_e st;
        logic [2:0] step;
        logic [5:0] idx;
        logic single;
        logic [23:0] page;
        logic req;
        logic [31:0] addr;
        logic write;
        logic [31:0] wdata;
        logic busy;
        logic done;
        logic fail;
        logic [BUF_WORDS-1:0][31:0] mem;
    } efpv_seq_s;

    efpv_seq_s s_q;
    efpv_seq_s s_d;

    logic x_done;
    logic [31:0] x_rdata;
    logic x_err;

    // ----------------------------------------
    // command word for a step of the sequence
    // ----------------------------------------
    function automatic logic [31:0] cmd_word(input logic single, input logic [2:0] step,
                                             input logic [23:0] page);
        logic [7:0] op;
        op = `EFPV_OP_PROG_LOAD;
        if (single) begin
            op = (step == 3'h0) ? `EFPV_OP_PROG_SINGLE : `EFPV_OP_VERIFY_SINGLE;
        end else begin
            case (step)
                3'h0: op = `EFPV_OP_PROG_LOAD;
                3'h1: op = `EFPV_OP_PROG_DATA_ADDR;
                3'h2: op = `EFPV_OP_PROG_LAUNCH;
                3'h3: op = `EFPV_OP_VERIFY_LOAD;
                3'h4: op = `EFPV_OP_VERIFY_DATA_ADDR;
                3'h5: op = `EFPV_OP_VERIFY_LAUNCH;
                default: op = `EFPV_OP_PROG_LOAD;
            endcase
        end
        cmd_word = '0;
        cmd_word[`EFPV_CMD_CODE_MSB:`EFPV_CMD_CODE_LSB] = op;
        cmd_word[`EFPV_CMD_PAGE_MSB:`EFPV_CMD_PAGE_LSB] = page;
    endfunction

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.req = 1'b0;
        s_d.done = 1'b0;
        // buffer frozen while a job runs so the array sees one coherent page
        if (load_en && !s_q.busy && (32'(load_idx) < BUF_WORDS)) begin
            s_d.mem[load_idx] = load_data;
        end
        if (x_done && x_err) begin
            s_d.fail = 1'b1;
        end
        case (s_q.st)
            EFPV_ST_IDLE: begin
                if (start) begin
                    s_d.st = EFPV_ST_CLAIM;
                    s_d.busy = 1'b1;
                    s_d.fail = 1'b0;
                    s_d.single = single_shot;
                    s_d.page = page_addr;
                    s_d.step = 3'h0;
                    s_d.req = 1'b1;
                    s_d.addr = `EFPV_ACCESS_CLAIM_OFS;
                    s_d.write = 1'b1;
                    s_d.wdata = `EFPV_ACCESS_CLAIM_VAL;
                end
            end
            EFPV_ST_CLAIM: begin
                if (x_done) begin
                    s_d.st = EFPV_ST_FILL;
                    s_d.idx = 6'h0;
                    s_d.req = 1'b1;
                    s_d.addr = `EFPV_WDBUF_BASE_OFS;
                    s_d.write = 1'b1;
                    s_d.wdata = s_q.mem[0];
                end
            end
            EFPV_ST_FILL: begin
                if (x_done) begin
                    s_d.req = 1'b1;
                    s_d.write = 1'b1;
                    if (32'(s_q.idx) == BUF_WORDS - 1) begin
                        // first command only once the whole buffer is written
                        s_d.st = EFPV_ST_CMD;
                        s_d.addr = `EFPV_CMD_OFS;
                        s_d.wdata = cmd_word(s_q.single, 3'h0, s_q.page);
                    end else begin
                        s_d.idx = s_q.idx + 6'h1;
                        s_d.addr = `EFPV_WDBUF_BASE_OFS + {24'h0, s_q.idx + 6'h1, 2'b00};
                        s_d.wdata = s_q.mem[s_q.idx + 6'h1];
                    end
                end
            end
            EFPV_ST_CMD: begin
                if (x_done) begin
                    s_d.st = EFPV_ST_POLL;
                    s_d.req = 1'b1;
                    s_d.addr = `EFPV_STATUS_OFS;
                    s_d.write = 1'b0;
                end
            end
            EFPV_ST_POLL: begin
                if (x_done) begin
                    s_d.req = 1'b1;
                    if (x_rdata[`EFPV_STATUS_BUSY_BIT]) begin
                        // controller holds busy until the command ends
                        s_d.addr = `EFPV_STATUS_OFS;
                        s_d.write = 1'b0;
                    end else begin
                        if (x_rdata[`EFPV_STATUS_ERR_BIT]) begin
                            s_d.fail = 1'b1;
                        end
                        s_d.write = 1'b1;
                        if (s_q.step == (s_q.single ? `EFPV_LAST_STEP_SINGLE
                                                    : `EFPV_LAST_STEP_SPLIT)) begin
                            s_d.st = EFPV_ST_FREE;
                            s_d.addr = `EFPV_ACCESS_CLAIM_OFS;
                            s_d.wdata = `EFPV_ACCESS_FREE_VAL;
                        end else begin
                            // next command only after the previous one completed
                            s_d.st = EFPV_ST_CMD;
                            s_d.step = s_q.step + 3'h1;
                            s_d.addr = `EFPV_CMD_OFS;
                            s_d.wdata = cmd_word(s_q.single, s_q.step + 3'h1, s_q.page);
                        end
                    end
                end
            end
            EFPV_ST_FREE: begin
                if (x_done) begin
                    s_d.st = EFPV_ST_IDLE;
                    s_d.busy = 1'b0;
                    s_d.done = 1'b1;
                end
            end
            default: begin
                s_d.st = EFPV_ST_IDLE;
                s_d.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy = s_q.busy;
    assign done = s_q.done;
    assign fail = s_q.fail;

    // ----------------------------------------
    // bus engine
    // ----------------------------------------
    efpv_ahb_xfer u_xfer (
        .clk(clk),
        .arst_n(arst_n),
        .req(s_q.req),
        .req_addr(s_q.addr),
        .req_write(s_q.write),
        .req_wdata(s_q.wdata),
        .done(x_done),
        .rdata(x_rdata),
        .err(x_err),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hresp(hresp),
        .hrdata(hrdata)
    );

endmodule

// *** efpv_seq_chk.sv ***
`timescale 1ns/1ps
`include "efpv_cfg.svh"

module efpv_seq_chk
    import efpv_pkg::*;
#(
    parameter int BUF_WORDS = 32
)(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // user side
    input wire logic load_en,
    input wire logic [5:0] load_idx,
    input wire logic [31:0] load_data,
    input wire logic start,
    input wire logic single_shot,
    input wire logic [23:0] page_addr,
    input wire logic busy,
    input wire logic done,
    input wire logic fail,
    // ahb-lite
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hresp,
    input wire logic [31:0] hrdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ----------------------------------------
    // data phase tracking
    // ----------------------------------------
    logic acc, dend, cmd_d, st_d, fc_d, buf_a, ph_v_q, ph_w_q, claimed_q, dev_busy_q, single_q;
    logic [31:0] ph_a_q;
    logic [23:0] page_q;
    logic [7:0] op_q;
    logic [6:0] wcnt_q;
    assign acc = htrans == `EFPV_HTRANS_NONSEQ && hready;
    assign dend = ph_v_q && hready;
    assign cmd_d = dend && ph_w_q && ph_a_q == `EFPV_CMD_OFS;
    assign st_d = dend && !ph_w_q && ph_a_q == `EFPV_STATUS_OFS;
    assign fc_d = dend && ph_w_q && ph_a_q == `EFPV_ACCESS_CLAIM_OFS;
    assign buf_a = haddr >= `EFPV_WDBUF_BASE_OFS
        && haddr < `EFPV_WDBUF_BASE_OFS + 32'(4 * BUF_WORDS);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {ph_v_q, ph_w_q, claimed_q, dev_busy_q, single_q} <= 5'h00;
            ph_a_q <= 32'h0;
            page_q <= 24'h0;
            op_q <= 8'h00;
            wcnt_q <= 7'h00;
        end else begin
            if (hready) begin
                ph_v_q <= acc;
                ph_a_q <= haddr;
                ph_w_q <= hwrite;
            end
            if (start && !busy) begin
                page_q <= page_addr;
                single_q <= single_shot;
                op_q <= single_shot ? `EFPV_OP_PROG_SINGLE : `EFPV_OP_PROG_LOAD;
                wcnt_q <= 7'h00;
            end
            if (acc && buf_a) wcnt_q <= wcnt_q + 7'h01;
            if (cmd_d) op_q <= op_q + 8'h01;
            if (cmd_d) dev_busy_q <= 1'b1;
            if (st_d) dev_busy_q <= hrdata[`EFPV_STATUS_BUSY_BIT];
            if (fc_d) claimed_q <= ~claimed_q;
        end
    end
    a_claim_first: assert property ($rose(busy) |=>
        htrans == `EFPV_HTRANS_NONSEQ && haddr == `EFPV_ACCESS_CLAIM_OFS && hwrite)
        else $error("first transfer is not the access claim");
    a_claim_value: assert property (fc_d |->
        hwdata == (claimed_q ? `EFPV_ACCESS_FREE_VAL : `EFPV_ACCESS_CLAIM_VAL))
        else $error("access claim write carries wrong value");
    a_addr_hold: assert property (htrans == `EFPV_HTRANS_NONSEQ && !hready |=>
        htrans == `EFPV_HTRANS_NONSEQ && $stable(haddr) && $stable(hwrite))
        else $error("address phase changed before ready");
    a_fill_order: assert property (acc && buf_a |->
        hwrite && haddr == `EFPV_WDBUF_BASE_OFS + {23'h0, wcnt_q, 2'b00})
        else $error("buffer write out of order");
    a_fill_first: assert property (acc && haddr == `EFPV_CMD_OFS |->
        hwrite && claimed_q && wcnt_q == BUF_WORDS)
        else $error("command before buffer filled");
    a_cmd_waits: assert property (acc && haddr == `EFPV_CMD_OFS |-> !dev_busy_q)
        else $error("command issued while previous one busy");
    a_poll_after: assert property (acc && dev_busy_q |->
        haddr == `EFPV_STATUS_OFS && !hwrite)
        else $error("no status poll after command");
    a_cmd_word: assert property (cmd_d |->
        hwdata[23:0] == page_q && hwdata[31:24] == op_q)
        else $error("command word wrong");
    a_release_last: assert property (fc_d && claimed_q |->
        !dev_busy_q && op_q == (single_q ? 8'h09 : 8'h07))
        else $error("release before last command finished");
    a_done_pulse: assert property ($rose(done) |-> $fell(busy) ##1 !done)
        else $error("done pulse misplaced");
endmodule

bind efpv_seq efpv_seq_chk #(.BUF_WORDS(BUF_WORDS)) u_chk (.clk(clk), .arst_n(arst_n),
    .load_en(load_en), .load_idx(load_idx), .load_data(load_data), .start(start),
    .single_shot(single_shot), .page_addr(page_addr), .busy(busy), .done(done), .fail(fail),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hresp(hresp), .hrdata(hrdata));

// *** efpv_dev_model.sv ***
`timescale 1ns/1ps
`include "efpv_cfg.svh"

module efpv_dev_model (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // ahb-lite slave
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    output logic hready,
    output logic hresp,
    output logic [31:0] hrdata,
    // test control
    input wire logic stall,
    input wire logic [7:0] lat,
    input wire logic [7:0] err_op
);
    logic dph_q, pw_q, claim_q, err_q, viol_q, cyc_q;
    logic [31:0] pa_q;
    logic [7:0] bcnt_q;
    logic [23:0] page_q;
    logic [47:0] op_log_q;
    logic [31:0] mem_q [0:63];
    assign hresp = 1'b0;
    // outside a read data phase the bus toggles so stale data never looks valid
    assign hrdata = (dph_q && !pw_q && pa_q == `EFPV_STATUS_OFS)
        ? {30'h0, err_q, bcnt_q != 8'h00} : {16{cyc_q, ~cyc_q}};
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {dph_q, pw_q, claim_q, err_q, viol_q, cyc_q} <= 6'h00;
            hready <= 1'b1;
            pa_q <= 32'h0;
            bcnt_q <= 8'h00;
            page_q <= 24'h0;
            op_log_q <= 48'h0;
            for (int i = 0; i < 64; i++) mem_q[i] <= 32'h0;
        end else begin
            cyc_q <= ~cyc_q;
            hready <= !stall;
            if (bcnt_q != 8'h00) bcnt_q <= bcnt_q - 8'h01;
            if (dph_q && hready) begin
                dph_q <= 1'b0;
                if (pw_q && pa_q == `EFPV_ACCESS_CLAIM_OFS) begin
                    claim_q <= hwdata[0];
                    if (hwdata[0]) op_log_q <= 48'h0;
                end
                // buffer window is 32 words; word i sits at base + 4*i
                if (pw_q && claim_q && pa_q >= `EFPV_WDBUF_BASE_OFS
                    && pa_q < `EFPV_WDBUF_BASE_OFS + 32'h80) begin
                    mem_q[6'((pa_q - `EFPV_WDBUF_BASE_OFS) >> 2)] <= hwdata;
                end
                if (pw_q && claim_q && pa_q == `EFPV_CMD_OFS) begin
                    viol_q <= viol_q | (bcnt_q != 8'h00);
                    bcnt_q <= lat;
                    err_q <= hwdata[31:24] == err_op;
                    op_log_q <= {op_log_q[39:0], hwdata[31:24]};
                    page_q <= hwdata[23:0];
                end
            end
            if (htrans[1] && hready) begin
                dph_q <= 1'b1;
                pa_q <= haddr;
                pw_q <= hwrite;
            end
        end
    end
endmodule

// *** test_embedded_flash_program_verify_seq.sv ***
`timescale 1ns/1ps
`include "efpv_cfg.svh"

module test_embedded_flash_program_verify_seq;
    import efpv_pkg::*;
    localparam int BW = 8;
    typedef struct {logic fail; logic [23:0] page; logic [47:0] ops; logic [31:0] sum;} efpv_note_s;
    logic clk, arst_n, load_en, start, single_shot, busy, done, fail, hwrite, hready, hresp;
    logic stall, slow;
    logic [5:0] load_idx;
    logic [31:0] load_data, haddr, hwdata, hrdata;
    logic [23:0] page_addr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] lat, err_op;
    int failures = 0, checks_done = 0, cycles = 0, seed = 13;
    efpv_note_s notes[$];

    efpv_seq #(.BUF_WORDS(BW)) dut (.clk(clk), .arst_n(arst_n), .load_en(load_en),
        .load_idx(load_idx), .load_data(load_data), .start(start), .single_shot(single_shot),
        .page_addr(page_addr), .busy(busy), .done(done), .fail(fail), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hresp(hresp), .hrdata(hrdata));
    efpv_dev_model dev (.clk(clk), .arst_n(arst_n), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hresp(hresp), .hrdata(hrdata),
        .stall(stall), .lat(lat), .err_op(err_op));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input string name, input logic [63:0] exp, input logic [63:0] seen);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        if (failures == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ----------------------------------------
    // result watcher and wait-state source
    // ----------------------------------------
    always @(posedge clk) begin : watch
        efpv_note_s n;
        logic [31:0] s;
        cycles++;
        if (cycles == 40000) begin
            failures++;
            finish_test();
        end
        stall <= slow && (($random(seed) & 3) == 0);
        if (done === 1'b1) begin
            n = notes.pop_front();
            s = 32'h0;
            for (int i = 0; i < BW; i++) s = {s[30:0], s[31]} ^ dev.mem_q[i];
            check("fail", 64'(n.fail), 64'(fail));
            check("page", 64'(n.page), 64'(dev.page_q));
            check("ops", 64'(n.ops), 64'(dev.op_log_q));
            check("buffer", 64'(n.sum), 64'(s));
            check("spare", 64'h0, 64'(dev.mem_q[BW]));
            check("claim", 64'h0, 64'(dev.claim_q));
            check("overlap", 64'h0, 64'(dev.viol_q));
            check("hsize", 64'(`EFPV_HSIZE_WORD), 64'(hsize));
        end
    end

    task automatic run_job(input logic ss, input logic [23:0] pg, input logic [7:0] eop,
        input logic sl);
        efpv_note_s n;
        logic [31:0] w;
        n.sum = 32'h0;
        for (int i = 0; i < BW; i++) begin
            w = $random(seed);
            @(posedge clk);
            load_en <= 1'b1;
            load_idx <= 6'(i);
            load_data <= w;
            n.sum = {n.sum[30:0], n.sum[31]} ^ w;
        end
        @(posedge clk);
        load_idx <= 6'(BW);
        load_data <= ~w;
        @(posedge clk);
        load_en <= 1'b0;
        start <= 1'b1;
        single_shot <= ss;
        page_addr <= pg;
        err_op <= eop;
        slow <= sl;
        lat <= sl ? 8'h28 : 8'h03;
        n.fail = eop != 8'h00;
        n.page = pg;
        n.ops = ss ? 48'h0000_0000_0708 : 48'h0102_0304_0506;
        notes.push_back(n);
        @(posedge clk);
        start <= 1'b0;
        repeat (30) @(posedge clk);
        // both must be ignored while busy
        start <= 1'b1;
        page_addr <= ~pg;
        load_en <= 1'b1;
        load_idx <= 6'h00;
        @(posedge clk);
        start <= 1'b0;
        load_en <= 1'b0;
        while (busy !== 1'b0) @(posedge clk);
        @(posedge clk);
    endtask

    initial begin
        {arst_n, load_en, start, single_shot, slow} = 5'h00;
        load_idx = 6'h00;
        load_data = 32'h0;
        page_addr = 24'h0;
        lat = 8'h03;
        err_op = 8'h00;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        run_job(1'b0, 24'h00_0010, 8'h00, 1'b0);
        run_job(1'b1, 24'hFF_FFFF, 8'h08, 1'b1);
        run_job(1'b0, 24'h12_3456, 8'h03, 1'b1);
        run_job(1'b1, 24'h00_0000, 8'h00, 1'b0);
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (40) @(posedge clk);
        arst_n <= 1'b0;
        @(posedge clk);
        check("htrans", 64'(`EFPV_HTRANS_IDLE), 64'(htrans));
        check("busy", 64'h0, 64'(busy));
        arst_n <= 1'b1;
        run_job(1'b0, 24'hA5_5A5A, 8'h06, 1'b0);
        finish_test();
    end
endmodule
